/* hw/irqe_defines.svh */
`ifndef IRQE_DEFINES_SVH
`define IRQE_DEFINES_SVH
// Operation
// - Bit 7 selects set or clear of 5..0
// - Bit 6 shows any enabled active request
// - Card found sets bit 5
// - Timer underflows set bits 4..0 in order
// - Inversion bit inverts interrupt pin
// - First enable bits gate first request flags
// - Second enable bits gate card, timer flags
// - Drive select: push-pull or open-drain pin
// - Pin gate lets global request reach pin
// - Bit 7 marks failed last memory command
// - Queue write in busy states sets bit 6
// - New command clears queue write fault
// - Multi-frame: clear after error flags stored
// - Write to full queue sets bit 5
// - After overflow, further writes are discarded
// - Queue, framing or parity fault sets summary
// - Send with empty queue sets bit 3
// - Framing fault sets bit 1, stops receive
// - Parity/CRC fault sets bit 0, receive continues

// ****************************************
// Register indices, byte address is four times
// ****************************************
`define IRQE_IDX_REQ0 8'h06
`define IRQE_IDX_REQ1 8'h07
`define IRQE_IDX_EN0 8'h08
`define IRQE_IDX_EN1 8'h09
`define IRQE_IDX_ERR 8'h0A

// ****************************************
// Field positions
// ****************************************
`define IRQE_SETCLR_BIT 7
`define IRQE_ANY_BIT 6
`define IRQE_INV_BIT 7
`define IRQE_DRIVE_BIT 7
`define IRQE_PINGATE_BIT 6
`define IRQE_FAULT_SUM_BIT 1
`define IRQE_ERR_NVM 7
`define IRQE_ERR_QWR 6
`define IRQE_ERR_OVL 5
`define IRQE_ERR_SHORT 4
`define IRQE_ERR_EMPTY 3
`define IRQE_ERR_COLL 2
`define IRQE_ERR_FRAME 1
`define IRQE_ERR_PARITY 0

// ****************************************
// Reset values and bus answers
// ****************************************
`define IRQE_RST_REG 8'h00
`define IRQE_RESP_OKAY 2'h0
`define IRQE_RESP_SLVERR 2'h2
`endif

/* hw/irqe_pkg.sv */
package irqe_pkg;
  // Decoded register write from the bus slave
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } irqe_wr_s;

  // Events from the transceiver, queue and memory logic
  typedef struct packed {
    logic nvm_done;
    logic nvm_fail;
    logic cmd_start;
    logic rx_phase_start;
    logic crc_sending;
    logic rx_busy;
    logic auth_active;
    logic multi_frame_receive;
    logic err_stored;
    logic send_req;
    logic fifo_empty;
    logic fifo_full;
    logic framing_fault;
    logic parity_crc_fault;
    logic short_frame_fault;
    logic collision_seen;
  } irqe_fault_ev_s;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_HAVE_AW,
    WR_HAVE_W,
    WR_RESP
  } irqe_wr_state_e;
endpackage

/* hw/irqe_axil_slave.sv */
`include "irqe_defines.svh"
module irqe_axil_slave import irqe_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic reg_wr,
  output irqe_wr_s reg_wr_cmd,
  input wire logic reg_wr_hit,
  output logic [7:0] reg_rd_idx,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_hit
);
  if (ADDR_W < 6 || ADDR_W > 10) begin : g_chk
    $error("ADDR_W must be 6 to 10");
  end

  irqe_wr_state_e state_ff, nxt_state;
  logic have_w_ff;
  logic [7:0] waddr_ff;
  logic [7:0] wdata_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic rvalid_ff;

  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire ar_take = arvalid && arready;
  wire [7:0] aw_idx = 8'(awaddr >> 2);
  // Both halves held: commit cycle, no second data word taken
  wire both_in = (state_ff == WR_HAVE_AW) && have_w_ff;

  assign awready = (state_ff == WR_IDLE) || (state_ff == WR_HAVE_W);
  assign wready = (state_ff == WR_IDLE) || ((state_ff == WR_HAVE_AW) && !have_w_ff);
  assign bvalid = (state_ff == WR_RESP);
  assign bresp = bresp_ff;
  // Write fires once both halves are in; byte lane 0 carries the register
  assign reg_wr = both_in && wlane_ff;
  assign reg_wr_cmd = '{idx: waddr_ff, data: wdata_ff};
  assign arready = !rvalid_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign reg_rd_idx = 8'(araddr >> 2);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WR_IDLE: begin
        if (aw_take) nxt_state = WR_HAVE_AW;
        else if (w_take) nxt_state = WR_HAVE_W;
      end
      WR_HAVE_AW: if (have_w_ff) nxt_state = WR_RESP;
      WR_HAVE_W: if (aw_take) nxt_state = WR_HAVE_AW;
      WR_RESP: if (bready) nxt_state = WR_IDLE;
      default: nxt_state = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= WR_IDLE;
      have_w_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (both_in) have_w_ff <= 1'b0;
      else if (w_take) have_w_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bresp_ff <= `IRQE_RESP_OKAY;
    end else begin
      if (aw_take) waddr_ff <= aw_idx;
      if (w_take) wdata_ff <= wdata[7:0];
      if (w_take) wlane_ff <= wstrb[0];
      if (both_in) bresp_ff <= reg_wr_hit ? `IRQE_RESP_OKAY : `IRQE_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `IRQE_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, reg_rd_data};
      rresp_ff <= reg_rd_hit ? `IRQE_RESP_OKAY : `IRQE_RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

/* hw/irqe_err_flags.sv */
`include "irqe_defines.svh"
module irqe_err_flags import irqe_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events
  input wire irqe_fault_ev_s ev,
  input wire logic fifo_wr,
  // Status
  output logic [7:0] err_flags,
  output logic fifo_wr_accept,
  output logic stop_receive
);
  logic [7:0] flags_ff;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  wire qwr_set = fifo_wr && (ev.crc_sending || ev.rx_busy || ev.auth_active);
  // Clear point depends on multi-frame mode
  wire qwr_clr = ev.multi_frame_receive ? ev.err_stored : ev.cmd_start;

  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`IRQE_ERR_QWR] = qwr_set;
    clr_v[`IRQE_ERR_QWR] = qwr_clr;
    set_v[`IRQE_ERR_OVL] = fifo_wr && ev.fifo_full;
    clr_v[`IRQE_ERR_OVL] = ev.cmd_start;
    set_v[`IRQE_ERR_EMPTY] = ev.send_req && ev.fifo_empty;
    clr_v[`IRQE_ERR_EMPTY] = ev.cmd_start;
    set_v[`IRQE_ERR_FRAME] = ev.framing_fault;
    clr_v[`IRQE_ERR_FRAME] = ev.rx_phase_start;
    set_v[`IRQE_ERR_PARITY] = ev.parity_crc_fault;
    clr_v[`IRQE_ERR_PARITY] = ev.rx_phase_start;
    set_v[`IRQE_ERR_SHORT] = ev.short_frame_fault;
    clr_v[`IRQE_ERR_SHORT] = ev.rx_phase_start;
    set_v[`IRQE_ERR_COLL] = ev.collision_seen;
    clr_v[`IRQE_ERR_COLL] = ev.rx_phase_start;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= `IRQE_RST_REG;
    end else begin
      // Set wins over a clear in the same cycle
      flags_ff[6:0] <= set_v[6:0] | (flags_ff[6:0] & ~clr_v[6:0]);
      // Tracks the most recent memory command
      if (ev.nvm_done) flags_ff[`IRQE_ERR_NVM] <= ev.nvm_fail;
    end
  end

  assign err_flags = flags_ff;
  assign fifo_wr_accept = !ev.fifo_full && !flags_ff[`IRQE_ERR_OVL];
  assign stop_receive = ev.framing_fault;
endmodule

/* hw/irqe_top.sv */
// Implementation choice: register access over AXI4-Lite.
`include "irqe_defines.svh"
module irqe_top import irqe_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int NUM_TIMERS = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // First group events, one-cycle pulses
  input wire logic high_level_ev,
  input wire logic low_level_ev,
  input wire logic cmd_done_ev,
  input wire logic send_done_ev,
  input wire logic receive_done_ev,
  input wire logic frame_start_ev,
  // Second group events, one-cycle pulses
  input wire logic card_found_ev,
  input wire logic [NUM_TIMERS-1:0] tmr_underflow_ev,
  // Fault events and queue writes
  input wire irqe_fault_ev_s fault_ev,
  input wire logic fifo_wr,
  output logic fifo_wr_accept,
  output logic stop_receive,
  // Interrupt pin
  output logic irq_pin_o,
  output logic irq_pin_oe
);
  if (NUM_TIMERS < 1 || NUM_TIMERS > 5) begin : g_chk
    $error("NUM_TIMERS must be 1 to 5");
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic reg_wr;
  irqe_wr_s reg_wr_cmd;
  logic [7:0] reg_rd_idx;
  logic [7:0] reg_rd_data;
  logic reg_rd_hit;
  logic reg_wr_hit;

  irqe_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_wr_cmd(reg_wr_cmd),
    .reg_wr_hit(reg_wr_hit),
    .reg_rd_idx(reg_rd_idx),
    .reg_rd_data(reg_rd_data),
    .reg_rd_hit(reg_rd_hit)
  );

  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == `IRQE_IDX_REQ0) || (idx == `IRQE_IDX_REQ1) || (idx == `IRQE_IDX_EN0) ||
                 (idx == `IRQE_IDX_EN1) || (idx == `IRQE_IDX_ERR);
  endfunction

  // Set or clear of one flag by a qualified write
  function automatic logic flag_next(input logic cur, input logic ev, input logic wr_sel,
                                     input logic wr_bit, input logic set_mode);
    logic hit;
    hit = wr_sel && wr_bit;
    if (ev) flag_next = 1'b1;
    else if (hit) flag_next = set_mode;
    else flag_next = cur;
  endfunction

  assign reg_wr_hit = idx_mapped(reg_wr_cmd.idx);
  assign reg_rd_hit = idx_mapped(reg_rd_idx);

  wire wr_req0 = reg_wr && (reg_wr_cmd.idx == `IRQE_IDX_REQ0);
  wire wr_req1 = reg_wr && (reg_wr_cmd.idx == `IRQE_IDX_REQ1);
  wire wr_en0 = reg_wr && (reg_wr_cmd.idx == `IRQE_IDX_EN0);
  wire wr_en1 = reg_wr && (reg_wr_cmd.idx == `IRQE_IDX_EN1);
  // Bit 7 selects set or clear
  wire set_mode = reg_wr_cmd.data[`IRQE_SETCLR_BIT];

  // ****************************************
  // Fault flags
  // ****************************************
  logic [7:0] err_flags;

  irqe_err_flags u_err (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(fault_ev),
    .fifo_wr(fifo_wr),
    .err_flags(err_flags),
    .fifo_wr_accept(fifo_wr_accept),
    .stop_receive(stop_receive)
  );

  // Summary from queue, framing and parity faults
  wire fault_any = err_flags[`IRQE_ERR_QWR] || err_flags[`IRQE_ERR_OVL] || err_flags[`IRQE_ERR_FRAME] ||
                   err_flags[`IRQE_ERR_EMPTY] || err_flags[`IRQE_ERR_PARITY];

  // ****************************************
  // Request flags
  // ****************************************
  logic [6:0] req0_ff;
  logic [5:0] req1_ff;
  logic [7:0] en0_ff;
  logic [7:0] en1_ff;
  logic any_request_flag_ff;
  logic [6:0] ev0;
  logic [5:0] ev1;
  logic [6:0] nxt_req0;
  logic [5:0] nxt_req1;

  assign ev0 = {high_level_ev, low_level_ev, cmd_done_ev, send_done_ev, receive_done_ev, fault_any,
                frame_start_ev};
  assign ev1[5] = card_found_ev;

  // Timer n lands in bit n
  for (genvar t = 0; t < 5; t++) begin : g_tmr
    if (t < NUM_TIMERS) begin : g_on
      assign ev1[t] = tmr_underflow_ev[t];
    end else begin : g_off
      assign ev1[t] = 1'b0;
    end
  end

  // Hardware events win over a software clear in the same cycle
  for (genvar i = 0; i < 7; i++) begin : g_req0
    assign nxt_req0[i] = flag_next(req0_ff[i], ev0[i], wr_req0, reg_wr_cmd.data[i], set_mode);
  end

  // Written ones in 5..0 follow bit 7
  for (genvar i = 0; i < 6; i++) begin : g_req1
    assign nxt_req1[i] = flag_next(req1_ff[i], ev1[i], wr_req1, reg_wr_cmd.data[i], set_mode);
  end

  wire [6:0] gated0 = req0_ff & en0_ff[6:0];
  wire [5:0] gated1 = req1_ff & en1_ff[5:0];
  // OR of gated flags every clock
  wire nxt_any_request_flag = (|gated0) || (|gated1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req0_ff <= 7'h00;
      req1_ff <= 6'h00;
    end else begin
      req0_ff <= nxt_req0;
      req1_ff <= nxt_req1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en0_ff <= `IRQE_RST_REG;
      en1_ff <= `IRQE_RST_REG;
    end else begin
      if (wr_en0) en0_ff <= reg_wr_cmd.data;
      if (wr_en1) en1_ff <= reg_wr_cmd.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) any_request_flag_ff <= 1'b0;
    else any_request_flag_ff <= nxt_any_request_flag;
  end

  // ****************************************
  // Interrupt pin
  // ****************************************
  // Pin gate
  wire pin_output_gate = en1_ff[`IRQE_PINGATE_BIT];
  wire pin_level = (any_request_flag_ff && pin_output_gate) ^ en0_ff[`IRQE_INV_BIT];
  wire pin_drive_select = en1_ff[`IRQE_DRIVE_BIT];

  // Open-drain drives only the low level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_o <= 1'b0;
      irq_pin_oe <= 1'b1;
    end else begin
      irq_pin_o <= pin_drive_select ? pin_level : 1'b0;
      irq_pin_oe <= pin_drive_select || !pin_level;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  wire sel_req0 = (reg_rd_idx == `IRQE_IDX_REQ0);
  wire sel_req1 = (reg_rd_idx == `IRQE_IDX_REQ1);
  wire sel_en0 = (reg_rd_idx == `IRQE_IDX_EN0);
  wire sel_en1 = (reg_rd_idx == `IRQE_IDX_EN1);
  wire sel_err = (reg_rd_idx == `IRQE_IDX_ERR);
  // Set-mode bit is write-only and reads as zero
  wire [7:0] req1_view = {1'b0, any_request_flag_ff, req1_ff};

  assign reg_rd_data = sel_req0 ? {1'b0, req0_ff} :
                       sel_req1 ? req1_view :
                       sel_en0 ? en0_ff :
                       sel_en1 ? en1_ff :
                       sel_err ? err_flags : 8'h00;
endmodule

/* testbench/irqe_top_props.sv */
// ****************************************
// Port checker for the interrupt block
// ****************************************
module irqe_top_props import irqe_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Queue and pin
  input wire irqe_fault_ev_s fault_ev,
  input wire logic fifo_wr,
  input wire logic fifo_wr_accept,
  input wire logic stop_receive,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ovl_write;
    fifo_wr && fault_ev.fifo_full;
  endsequence
  // Write excluded: set wins over the restart clear
  sequence s_restart;
    fault_ev.cmd_start && !fifo_wr ##1 !fault_ev.fifo_full;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr[7:2] < 6'h06 || s_axi_araddr[7:2] > 6'h0A) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_stop_rx: assert property (stop_receive == fault_ev.framing_fault)
    else $error("receive stop mismatch");
  a_full_refuse: assert property (fault_ev.fifo_full |-> !fifo_wr_accept)
    else $error("full queue accepts");
  a_ovl_set: assert property (s_ovl_write |=> !fifo_wr_accept)
    else $error("overflow not flagged");
  a_ovl_hold: assert property (!fifo_wr_accept && !fault_ev.fifo_full && !fault_ev.cmd_start |=> !fifo_wr_accept)
    else $error("overflow lock lost");
  a_ovl_clear: assert property (s_restart |-> fifo_wr_accept)
    else $error("overflow not cleared");
  a_pin_drive: assert property (irq_pin_o |-> irq_pin_oe)
    else $error("pin high while released");
endmodule
bind irqe_top irqe_top_props #(.ADDR_W(ADDR_W)) i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .fault_ev(fault_ev), .fifo_wr(fifo_wr), .fifo_wr_accept(fifo_wr_accept),
  .stop_receive(stop_receive), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe)
);

/* testbench/irqe_host_model.sv */
// ****************************************
// Host side of the interrupt pin
// ****************************************
module irqe_host_model (
  // Pin as driven by the block
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe,
  // Level seen by the host
  output logic irq_line
);
  timeunit 1ns;
  timeprecision 1ns;
  assign irq_line = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule

/* testbench/irqe_tb_top.sv */
module irqe_tb_top import irqe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] en0;
    logic [7:0] en1;
    logic [5:0] e0;
    logic [5:0] e1;
    logic [7:0] req1;
    logic line;
    logic oe;
  } irqe_row_s;
  localparam logic [7:0] A_REQ0 = 8'h18;
  localparam logic [7:0] A_REQ1 = 8'h1C;
  localparam logic [7:0] A_EN0 = 8'h20;
  localparam logic [7:0] A_EN1 = 8'h24;
  localparam logic [7:0] A_ERR = 8'h28;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, accept, stop_rx, pin_o, pin_oe, irq_line;
  logic [1:0] bresp, rresp, resp, rr;
  logic [31:0] rdata;
  logic [5:0] ev0 = 6'h00;
  logic [5:0] ev1 = 6'h00;
  irqe_fault_ev_s fev = '0;
  logic fwr = 1'b0;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Pin level rows: enables, events, flags and pin seen
  irqe_row_s rows [10] = '{'{8'h00, 8'hC1, 6'h00, 6'h01, 8'h41, 1'b1, 1'b1},
    '{8'h00, 8'hC1, 6'h00, 6'h02, 8'h02, 1'b0, 1'b1}, '{8'h80, 8'hC1, 6'h00, 6'h01, 8'h41, 1'b0, 1'b1},
    '{8'h80, 8'h60, 6'h00, 6'h20, 8'h60, 1'b0, 1'b1}, '{8'h00, 8'h60, 6'h00, 6'h20, 8'h60, 1'b1, 1'b0},
    '{8'h00, 8'hA0, 6'h00, 6'h20, 8'h60, 1'b0, 1'b1}, '{8'h00, 8'hDF, 6'h00, 6'h10, 8'h50, 1'b1, 1'b1},
    '{8'h04, 8'hC0, 6'h02, 6'h00, 8'h40, 1'b1, 1'b1}, '{8'h04, 8'hC0, 6'h04, 6'h00, 8'h00, 1'b0, 1'b1},
    '{8'h80, 8'h80, 6'h00, 6'h01, 8'h01, 1'b1, 1'b1}};
  irqe_top #(.ADDR_W(8), .NUM_TIMERS(5)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .high_level_ev(ev0[5]), .low_level_ev(ev0[4]), .cmd_done_ev(ev0[3]),
    .send_done_ev(ev0[2]), .receive_done_ev(ev0[1]), .frame_start_ev(ev0[0]),
    .card_found_ev(ev1[5]), .tmr_underflow_ev(ev1[4:0]),
    .fault_ev(fev), .fifo_wr(fwr), .fifo_wr_accept(accept), .stop_receive(stop_rx),
    .irq_pin_o(pin_o), .irq_pin_oe(pin_oe)
  );
  irqe_host_model i_host (.irq_pin_o(pin_o), .irq_pin_oe(pin_oe), .irq_line(irq_line));
  always #20 aclk = ~aclk;
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard, far above the planned run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Extra edge at the end keeps strobes from toggling twice in one step
  task automatic axw(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [7:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    rr = rresp;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    axr(a, d);
    chk(d, e);
  endtask
  task automatic evp(input logic [5:0] a, input logic [5:0] b);
    ev0 <= a;
    ev1 <= b;
    @(posedge aclk);
    ev0 <= 6'h00;
    ev1 <= 6'h00;
    repeat (4) @(posedge aclk);
  endtask
  task automatic fstep(input irqe_fault_ev_s v, input logic wr);
    fev <= v;
    fwr <= wr;
    @(posedge aclk);
    fev <= '0;
    fwr <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    irqe_fault_ev_s fv;
    logic [7:0] d;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (logic [7:0] a = A_REQ0; a <= A_ERR; a += 8'h04) begin
      rc(a, 8'h00);
    end
    foreach (rows[i]) begin
      axw(A_EN0, rows[i].en0);
      axw(A_EN1, rows[i].en1);
      axw(A_REQ1, 8'h3F);
      axw(A_REQ0, 8'h7F);
      evp(rows[i].e0, rows[i].e1);
      chk({7'h0, irq_line}, {7'h0, rows[i].line});
      chk({7'h0, pin_oe}, {7'h0, rows[i].oe});
      rc(A_REQ1, rows[i].req1);
    end
    axw(A_EN1, 8'h00);
    axw(A_REQ1, 8'hA5);
    rc(A_REQ1, 8'h25);
    axw(A_REQ1, 8'h05);
    rc(A_REQ1, 8'h20);
    axw(A_REQ1, 8'hCA);
    rc(A_REQ1, 8'h2A);
    axr(8'h3C, d);
    chk({6'h0, rr}, 8'h02);
    axw(8'h3C, 8'hFF);
    chk({6'h0, resp}, 8'h02);
    axw(A_ERR, 8'hFF);
    rc(A_ERR, 8'h00);
    fv = '0;
    fv.nvm_done = 1'b1;
    fv.nvm_fail = 1'b1;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h80);
    fv.nvm_fail = 1'b0;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h00);
    fv = '0;
    fstep(fv, 1'b1);
    rc(A_ERR, 8'h00);
    for (int k = 0; k < 3; k++) begin
      fv = '0;
      fv.crc_sending = (k == 0);
      fv.rx_busy = (k == 1);
      fv.auth_active = (k == 2);
      fstep(fv, 1'b1);
      rc(A_ERR, 8'h40);
      rc(A_REQ0, 8'h02);
      axw(A_REQ0, 8'h02);
      fv = '0;
      fv.cmd_start = 1'b1;
      fstep(fv, 1'b0);
      rc(A_ERR, 8'h00);
    end
    fv = '0;
    fv.rx_busy = 1'b1;
    fv.multi_frame_receive = 1'b1;
    fstep(fv, 1'b1);
    fv.rx_busy = 1'b0;
    fv.cmd_start = 1'b1;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h40);
    fv.cmd_start = 1'b0;
    fv.err_stored = 1'b1;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h00);
    fv = '0;
    fv.fifo_full = 1'b1;
    fstep(fv, 1'b1);
    chk({7'h0, accept}, 8'h00);
    rc(A_ERR, 8'h20);
    fv = '0;
    fv.send_req = 1'b1;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h20);
    fv.fifo_empty = 1'b1;
    fv.framing_fault = 1'b1;
    fv.parity_crc_fault = 1'b1;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h2B);
    fv = '0;
    fv.rx_phase_start = 1'b1;
    fstep(fv, 1'b0);
    rc(A_ERR, 8'h28);
    fv = '0;
    fv.cmd_start = 1'b1;
    fstep(fv, 1'b0);
    chk({7'h0, accept}, 8'h01);
    rc(A_ERR, 8'h00);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(A_EN0, 8'h00);
    report_and_stop();
  end
endmodule
